// ### common/timer16_pkg.sv
// constants for the 16-bit counter and input-capture block
// Operation
// - clock-select zero stops the counter
// - counter clears, counts up or down per mode
// - upper-byte access hits latch; low read fills it
// - low-byte write loads all 16 bits together
// - CPU write beats clear or count
// - counter accessible with or without count clock
// - mode field sets sequence and overflow point
// - selected edge copies counter into capture register
// - capture flag set with the copy
// - capture flag cleared by ack or write-one
// - capture low read loads its upper byte latch
// - capture writable only in capture-top modes
// - comparator select switches trigger; clear flag after
// - capture input ignored in capture-top modes
// - filter output changes after four agreeing samples
// - filter adds four system clocks delay
// - new capture overwrites unread value
// - pin drives capture whoever drives the pin
// - capture input sampled like external count clock
// - upper byte first, one-cycle transfer on low
package timer16_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
	localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h2;
	localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h3;
	localparam logic [3:0] ADDR_CONTROL_A = 4'h4;
	localparam logic [3:0] ADDR_CONTROL_B = 4'h5;
	localparam logic [3:0] ADDR_FLAGS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
	localparam logic [3:0] ADDR_COMP_CTRL = 4'h8;
	// control_reg_a: waveform mode bits 1:0
	localparam int CTRL_A_WGM_LSB = 0;
	// control_reg_b fields
	localparam int CTRL_B_CS_LSB = 0;
	localparam int CTRL_B_WGM_LSB = 3;
	localparam int CTRL_B_EDGE_BIT = 6;
	localparam int CTRL_B_FILTER_BIT = 7;
	// flag and mask bit positions
	localparam int OVERFLOW_BIT = 0;
	localparam int CAPTURE_BIT = 5;
	// comparator_ctrl_status fields
	localparam int COMP_SELECT_BIT = 2;
	localparam int COMP_OUT_BIT = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam int FILTER_SAMPLES = 4;
	localparam int PRESCALE_W = 10;
	// clock-select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} dir_t;
endpackage

// ### logic/edge_sampler.sv
// sampling, optional four-sample filter and edge detection of one input
`timescale 1ns/1ps
module edge_sampler
	import timer16_pkg::*;
#(
	parameter int SAMPLES = FILTER_SAMPLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic sig_in,
	input wire logic filter_en,
	output logic rise,
	output logic fall
);
	logic sample_q;
	logic [SAMPLES-2:0] hist_q;
	logic filt_q;
	logic prev_q;
	logic cond;
	// newest sample plus the older ones make the agreement window
	wire [SAMPLES-1:0] window = {hist_q, sample_q};
	wire all_high = &window;
	wire all_low = ~|window;
	if (SAMPLES < 2) begin
		$error("edge_sampler needs at least two samples");
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_q <= 1'b0;
			hist_q <= '0;
			filt_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sample_q <= sig_in;
			hist_q <= (SAMPLES-1)'({hist_q, sample_q});
			if (all_high) begin
				filt_q <= 1'b1;
			end else if (all_low) begin
				filt_q <= 1'b0;
			end
			prev_q <= cond;
		end
	end
	// filter path is four clocks later than the plain sample
	assign cond = filter_en ? filt_q : sample_q;
	assign rise = cond & ~prev_q;
	assign fall = ~cond & prev_q;
endmodule

// ### logic/timer16_counter_input_capture.sv
// 16-bit counter with shared byte latch and input capture
`timescale 1ns/1ps
module timer16_counter_input_capture
	import timer16_pkg::*;
#(
	parameter int DIV_A = 8,
	parameter int DIV_B = 64,
	parameter int DIV_C = 256,
	parameter int DIV_D = 1024
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic ext_clock_pin,
	input wire logic capture_irq_ack,
	input wire logic overflow_irq_ack,
	output logic capture_irq,
	output logic overflow_irq
);
	logic [15:0] count_value_q;
	logic [15:0] count_value_d;
	logic [15:0] capture_value_q;
	logic [15:0] capture_value_d;
	logic [7:0] temp_q;
	logic [7:0] temp_d;
	logic [7:0] control_reg_a_q;
	logic [7:0] control_reg_b_q;
	logic [7:0] irq_mask_q;
	logic comparator_capture_select_q;
	logic capture_flag_q;
	logic capture_flag_d;
	logic overflow_flag_q;
	logic overflow_flag_d;
	logic [PRESCALE_W-1:0] pre_q;
	logic [7:0] rdata_q;
	logic capture_irq_q;
	logic overflow_irq_q;
	dir_t dir_q;
	dir_t dir_d;
	logic ovf_set;
	logic ext_rise;
	logic ext_fall;
	logic cap_rise;
	logic cap_fall;

	if (DIV_A < 2 || DIV_D > (1 << PRESCALE_W)) begin
		$error("prescale divide out of range");
	end
	if ((DIV_A & (DIV_A - 1)) != 0 || (DIV_B & (DIV_B - 1)) != 0
		|| (DIV_C & (DIV_C - 1)) != 0 || (DIV_D & (DIV_D - 1)) != 0) begin
		$error("divides must be powers of two");
	end

	function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cap);
		case (mode)
			4'd1, 4'd5: top_of = TOP_8BIT;
			4'd2, 4'd6: top_of = TOP_9BIT;
			4'd3, 4'd7: top_of = TOP_10BIT;
			4'd8, 4'd10, 4'd12, 4'd14: top_of = cap;
			default: top_of = COUNT_MAX;
		endcase
	endfunction

	function automatic logic is_cap_top(input logic [3:0] mode);
		is_cap_top = (mode == 4'd8) || (mode == 4'd10) || (mode == 4'd12) || (mode == 4'd14);
	endfunction

	function automatic logic pre_tick(input logic [PRESCALE_W-1:0] cnt, input int div);
		logic [PRESCALE_W-1:0] mask;
		mask = PRESCALE_W'(div - 1);
		pre_tick = (cnt & mask) == mask;
	endfunction

	// bus decode
	wire wr_count_low = bus_wr && (bus_addr == ADDR_COUNT_LOW);
	wire wr_capture_low = bus_wr && (bus_addr == ADDR_CAPTURE_LOW);
	wire wr_high = bus_wr && ((bus_addr == ADDR_COUNT_HIGH) || (bus_addr == ADDR_CAPTURE_HIGH));
	wire rd_count_low = bus_rd && (bus_addr == ADDR_COUNT_LOW);
	wire rd_capture_low = bus_rd && (bus_addr == ADDR_CAPTURE_LOW);
	wire wr_ctrl_a = bus_wr && (bus_addr == ADDR_CONTROL_A);
	wire wr_ctrl_b = bus_wr && (bus_addr == ADDR_CONTROL_B);
	wire wr_flags = bus_wr && (bus_addr == ADDR_FLAGS);
	wire wr_mask = bus_wr && (bus_addr == ADDR_IRQ_MASK);
	wire wr_comp = bus_wr && (bus_addr == ADDR_COMP_CTRL);

	// control fields
	wire [2:0] count_clock_select = control_reg_b_q[CTRL_B_CS_LSB +: 3];
	wire [3:0] waveform_mode_field = {control_reg_b_q[CTRL_B_WGM_LSB +: 2], control_reg_a_q[CTRL_A_WGM_LSB +: 2]};
	wire capture_edge_rising = control_reg_b_q[CTRL_B_EDGE_BIT];
	wire capture_filter_enable = control_reg_b_q[CTRL_B_FILTER_BIT];
	wire capture_irq_enable = irq_mask_q[CAPTURE_BIT];
	wire overflow_irq_enable = irq_mask_q[OVERFLOW_BIT];
	wire cap_top_mode = is_cap_top(waveform_mode_field);
	wire [15:0] top_value = top_of(waveform_mode_field, capture_value_q);
	wire dual_slope = (waveform_mode_field inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
	wire fast_pwm = (waveform_mode_field inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15});

	// count clock selection
	logic count_clock;
	always_comb begin
		case (count_clock_select)
			CS_STOP: count_clock = 1'b0;
			CS_DIV1: count_clock = 1'b1;
			CS_DIV8: count_clock = pre_tick(pre_q, DIV_A);
			CS_DIV64: count_clock = pre_tick(pre_q, DIV_B);
			CS_DIV256: count_clock = pre_tick(pre_q, DIV_C);
			CS_DIV1024: count_clock = pre_tick(pre_q, DIV_D);
			CS_EXT_FALL: count_clock = ext_fall;
			CS_EXT_RISE: count_clock = ext_rise;
			default: count_clock = 1'b0;
		endcase
	end

	edge_sampler #(
		.SAMPLES(FILTER_SAMPLES)
	) ext_sampler (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.sig_in(ext_clock_pin),
		.filter_en(1'b0),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	// trigger source; pin level is sampled no matter who drives it
	wire capture_source = comparator_capture_select_q ? comparator_output : capture_pin;

	edge_sampler #(
		.SAMPLES(FILTER_SAMPLES)
	) cap_sampler (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.sig_in(capture_source),
		.filter_en(capture_filter_enable),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	// input disabled while capture register defines top
	wire capture_event = ~cap_top_mode & (capture_edge_rising ? cap_rise : cap_fall);

	// counter sequence
	always_comb begin
		count_value_d = count_value_q;
		dir_d = dir_q;
		ovf_set = 1'b0;
		if (count_clock) begin
			if (dual_slope) begin
				case (dir_q)
					DIR_UP: begin
						if (count_value_q >= top_value) begin
							dir_d = DIR_DOWN;
							count_value_d = count_value_q - 16'h0001;
						end else begin
							count_value_d = count_value_q + 16'h0001;
						end
					end
					DIR_DOWN: begin
						if (count_value_q == COUNT_RESET) begin
							dir_d = DIR_UP;
							count_value_d = count_value_q + 16'h0001;
							ovf_set = 1'b1;
						end else begin
							count_value_d = count_value_q - 16'h0001;
						end
					end
					default: begin
						dir_d = DIR_UP;
					end
				endcase
			end else begin
				dir_d = DIR_UP;
				if (count_value_q == top_value || count_value_q == COUNT_MAX) begin
					count_value_d = COUNT_RESET;
					ovf_set = fast_pwm || (count_value_q == COUNT_MAX);
				end else begin
					count_value_d = count_value_q + 16'h0001;
				end
			end
		end
		if (wr_count_low) begin
			count_value_d = {temp_q, bus_wdata};
		end
	end

	// shared upper-byte latch
	always_comb begin
		temp_d = temp_q;
		if (wr_high) begin
			temp_d = bus_wdata;
		end else if (rd_count_low) begin
			temp_d = count_value_q[15:8];
		end else if (rd_capture_low) begin
			temp_d = capture_value_q[15:8];
		end
	end

	// capture register
	always_comb begin
		capture_value_d = capture_value_q;
		if (capture_event) begin
			capture_value_d = count_value_q;
		end else if (wr_capture_low && cap_top_mode) begin
			capture_value_d = {temp_q, bus_wdata};
		end
	end

	// flags: a set in the clearing cycle wins
	wire clr_capture = capture_irq_ack || (wr_flags && bus_wdata[CAPTURE_BIT]);
	wire clr_overflow = overflow_irq_ack || (wr_flags && bus_wdata[OVERFLOW_BIT]);
	assign capture_flag_d = capture_event | (capture_flag_q & ~clr_capture);
	assign overflow_flag_d = ovf_set | (overflow_flag_q & ~clr_overflow);

	// read data
	logic [7:0] rd_mux;
	always_comb begin
		case (bus_addr)
			ADDR_COUNT_LOW: rd_mux = count_value_q[7:0];
			ADDR_COUNT_HIGH: rd_mux = temp_q;
			ADDR_CAPTURE_LOW: rd_mux = capture_value_q[7:0];
			ADDR_CAPTURE_HIGH: rd_mux = temp_q;
			ADDR_CONTROL_A: rd_mux = control_reg_a_q;
			ADDR_CONTROL_B: rd_mux = control_reg_b_q;
			ADDR_FLAGS: rd_mux = 8'(({7'h00, capture_flag_q} << CAPTURE_BIT) | ({7'h00, overflow_flag_q} << OVERFLOW_BIT));
			ADDR_IRQ_MASK: rd_mux = irq_mask_q;
			ADDR_COMP_CTRL: rd_mux = 8'(({7'h00, comparator_output} << COMP_OUT_BIT)
				| ({7'h00, comparator_capture_select_q} << COMP_SELECT_BIT));
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_value_q <= COUNT_RESET;
			capture_value_q <= COUNT_RESET;
			temp_q <= CTRL_RESET;
			dir_q <= DIR_UP;
			pre_q <= '0;
		end else begin
			count_value_q <= count_value_d;
			capture_value_q <= capture_value_d;
			temp_q <= temp_d;
			dir_q <= dir_d;
			pre_q <= pre_q + PRESCALE_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			control_reg_a_q <= CTRL_RESET;
			control_reg_b_q <= CTRL_RESET;
			irq_mask_q <= CTRL_RESET;
			comparator_capture_select_q <= 1'b0;
		end else begin
			if (wr_ctrl_a) control_reg_a_q <= bus_wdata & 8'h03;
			if (wr_ctrl_b) control_reg_b_q <= bus_wdata & 8'hdf;
			if (wr_mask) irq_mask_q <= bus_wdata & 8'h21;
			if (wr_comp) comparator_capture_select_q <= bus_wdata[COMP_SELECT_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_flag_q <= 1'b0;
			overflow_flag_q <= 1'b0;
			rdata_q <= 8'h00;
			capture_irq_q <= 1'b0;
			overflow_irq_q <= 1'b0;
		end else begin
			capture_flag_q <= capture_flag_d;
			overflow_flag_q <= overflow_flag_d;
			if (bus_rd) rdata_q <= rd_mux;
			capture_irq_q <= capture_flag_d & capture_irq_enable;
			overflow_irq_q <= overflow_flag_d & overflow_irq_enable;
		end
	end

	assign bus_rdata = rdata_q;
	assign capture_irq = capture_irq_q;
	assign overflow_irq = overflow_irq_q;
endmodule

// ### tb/timer16_asserts.sv
// port assertions for the counter and input-capture block
`timescale 1ns/1ps
module timer16_asserts
	import timer16_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic capture_irq_ack,
	input wire logic overflow_irq_ack,
	input wire logic capture_irq,
	input wire logic overflow_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic pin_q, comp_q;
	logic [3:0] quiet_q;
	// cycles since a source change or any write
	wire stir = (capture_pin != pin_q) || (comparator_output != comp_q) || bus_wr;
	wire [3:0] quiet_d = stir ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_q <= 1'b0;
			comp_q <= 1'b0;
			quiet_q <= 4'h0;
		end else begin
			pin_q <= capture_pin;
			comp_q <= comparator_output;
			quiet_q <= quiet_d;
		end
	end
	sequence s_idle;
		!bus_wr && !bus_rd;
	endsequence
	sequence s_cap_hi_read;
		bus_rd && bus_addr == ADDR_CAPTURE_HIGH;
	endsequence
	a_latch_echo: assert property (bus_wr && bus_addr == ADDR_COUNT_HIGH ##1 s_idle ##1 s_cap_hi_read
		|=> bus_rdata == $past(bus_wdata, 3)) else $error("high read misses written latch");
	a_latch_shared: assert property (bus_rd && bus_addr == ADDR_COUNT_HIGH ##1 s_idle ##1 s_cap_hi_read
		|=> bus_rdata == $past(bus_rdata, 2)) else $error("high locations disagree");
	a_cap_ack_clear: assert property (capture_irq_ack && !bus_wr && quiet_q >= 4'h8
		|-> ##2 !capture_irq) else $error("capture ack did not clear");
	a_cap_cause: assert property ($rose(capture_irq) |-> quiet_q <= 4'ha)
		else $error("capture without source edge");
	a_cap_flag_read: assert property (bus_rd && bus_addr == ADDR_FLAGS && capture_irq
		&& !$past(capture_irq_ack) && !$past(bus_wr) |=> bus_rdata[CAPTURE_BIT]) else $error("capture flag reads low");
	a_ovf_flag_read: assert property (bus_rd && bus_addr == ADDR_FLAGS && overflow_irq
		&& !$past(overflow_irq_ack) && !$past(bus_wr) |=> bus_rdata[OVERFLOW_BIT]) else $error("overflow flag reads low");
	a_cap_mask_off: assert property (bus_wr && bus_addr == ADDR_IRQ_MASK && !bus_wdata[CAPTURE_BIT]
		|-> ##2 !capture_irq) else $error("masked capture request");
	a_ovf_mask_off: assert property (bus_wr && bus_addr == ADDR_IRQ_MASK && !bus_wdata[OVERFLOW_BIT]
		|-> ##2 !overflow_irq) else $error("masked overflow request");
endmodule
bind timer16_counter_input_capture timer16_asserts i_chk (.core_clk(core_clk), .reset_n(reset_n),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.capture_pin(capture_pin), .comparator_output(comparator_output), .capture_irq_ack(capture_irq_ack),
	.overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq), .overflow_irq(overflow_irq));

// ### tb/capture_source.sv
// far-side model: capture pin, comparator output and external clock
`timescale 1ns/1ps
module capture_source (
	input wire logic core_clk,
	output logic capture_pin,
	output logic comparator_output,
	output logic ext_clock_pin
);
	initial begin
		capture_pin = 1'b0;
		comparator_output = 1'b0;
		ext_clock_pin = 1'b0;
	end
	task automatic set_pin(input logic v);
		@(negedge core_clk);
		capture_pin = v;
	endtask
	task automatic pulse_pin(input int w);
		set_pin(1'b1);
		repeat (w) @(negedge core_clk);
		capture_pin = 1'b0;
	endtask
	task automatic set_comp(input logic v);
		@(negedge core_clk);
		comparator_output = v;
	endtask
	task automatic tick_ext(input int n);
		repeat (n) begin
			@(negedge core_clk);
			ext_clock_pin = 1'b1;
			repeat (2) @(negedge core_clk);
			ext_clock_pin = 1'b0;
			repeat (2) @(negedge core_clk);
		end
	endtask
endmodule

// ### tb/timer16_counter_input_capture_tb.sv
// self-checking bench for the counter and input-capture block
`timescale 1ns/1ps
module timer16_counter_input_capture_tb
	import timer16_pkg::*;
;
	logic core_clk;
	logic reset_n;
	logic [ADDR_W-1:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic capture_irq_ack;
	logic overflow_irq_ack;
	logic [7:0] bus_rdata;
	logic capture_pin, comparator_output, ext_clock_pin, capture_irq, overflow_irq;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h00000022;
	always #5 core_clk = ~core_clk;
	capture_source i_src (.core_clk(core_clk), .capture_pin(capture_pin),
		.comparator_output(comparator_output), .ext_clock_pin(ext_clock_pin));
	timer16_counter_input_capture #(.DIV_A(2), .DIV_B(4), .DIV_C(8), .DIV_D(16)) i_dut (
		.core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .capture_pin(capture_pin),
		.comparator_output(comparator_output), .ext_clock_pin(ext_clock_pin),
		.capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
		.capture_irq(capture_irq), .overflow_irq(overflow_irq));
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [7:0] ctl(input logic flt, input logic edg);
		return (8'(flt) << CTRL_B_FILTER_BIT) | (8'(edg) << CTRL_B_EDGE_BIT);
	endfunction
	function automatic logic fits(input int d, input logic [15:0] r);
		return (int'(r) + 2 >= 66 / d) && (int'(r) <= 66 / d + 1);
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge core_clk);
		bus_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge core_clk);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a + 4'h1, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
	endtask
	task automatic wait_irq(input logic ovf, output int n);
		for (n = 0; n < 40; n++) begin
			if ((ovf ? overflow_irq : capture_irq) === 1'b1) break;
			@(negedge core_clk);
		end
		if (n == 40) begin
			fail_count++;
			wrap_up();
		end
	endtask
	// five count clocks from start, then stop
	task automatic spin(input logic [7:0] cb, input logic [15:0] start);
		wr16(ADDR_COUNT_LOW, start);
		wr(ADDR_CONTROL_B, cb);
		repeat (3) @(negedge core_clk);
		wr(ADDR_CONTROL_B, CTRL_RESET);
	endtask
	task automatic ack(input logic ovf);
		@(negedge core_clk);
		overflow_irq_ack = ovf;
		capture_irq_ack = !ovf;
		@(negedge core_clk);
		overflow_irq_ack = 1'b0;
		capture_irq_ack = 1'b0;
		@(negedge core_clk);
	endtask
	initial begin
		logic [15:0] v, r;
		logic [7:0] d;
		int i, n, lat0;
		core_clk = 1'b0;
		reset_n = 1'b0;
		bus_addr = 4'h0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		capture_irq_ack = 1'b0;
		overflow_irq_ack = 1'b0;
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		rd(ADDR_CONTROL_B, d);
		chk(d, CTRL_RESET);
		rd(4'hf, d);
		chk(d, 8'h00);
		for (i = 0; i < 4; i++) begin
			v = rnd();
			wr16(ADDR_COUNT_LOW, v);
			repeat (3) @(negedge core_clk);
			rd16(ADDR_COUNT_LOW, r);
			chk(r, v);
			rd(ADDR_CAPTURE_HIGH, d);
			chk(d, v[15:8]);
		end
		wr(ADDR_COUNT_HIGH, v[7:0]);
		rd(ADDR_CAPTURE_HIGH, d);
		chk(d, v[7:0]);
		for (i = 1; i < 6; i++) begin
			wr16(ADDR_COUNT_LOW, 16'h0000);
			wr(ADDR_CONTROL_B, 8'(i));
			repeat (64) @(negedge core_clk);
			wr(ADDR_CONTROL_B, CTRL_RESET);
			rd16(ADDR_COUNT_LOW, r);
			chk(fits(1 << (i - 1), r), 1'b1);
		end
		wr16(ADDR_COUNT_LOW, 16'h0000);
		wr(ADDR_CONTROL_B, {5'h00, CS_EXT_RISE});
		i_src.tick_ext(3);
		wr(ADDR_CONTROL_B, CTRL_RESET);
		rd16(ADDR_COUNT_LOW, r);
		chk(r, 16'h0003);
		wr(ADDR_IRQ_MASK, 8'h21);
		wr(ADDR_CONTROL_B, {5'h00, CS_DIV1});
		wr16(ADDR_COUNT_LOW, 16'hfffd);
		wait_irq(1'b1, n);
		rd(ADDR_FLAGS, d);
		chk(d[OVERFLOW_BIT], 1'b1);
		wr(ADDR_CONTROL_B, CTRL_RESET);
		ack(1'b1);
		chk(overflow_irq, 1'b0);
		wr(ADDR_IRQ_MASK, 8'h20);
		wr(ADDR_CONTROL_A, 8'h01);
		spin({5'h00, CS_DIV1}, 16'h00fe);
		rd16(ADDR_COUNT_LOW, r);
		chk(r, 16'h00fb);
		spin({5'h00, CS_DIV1}, 16'h0003);
		rd16(ADDR_COUNT_LOW, r);
		chk(r, 16'h0002);
		rd(ADDR_FLAGS, d);
		chk(d[OVERFLOW_BIT], 1'b1);
		wr(ADDR_FLAGS, 8'h01);
		spin(8'h08 | {5'h00, CS_DIV1}, 16'h00fe);
		rd16(ADDR_COUNT_LOW, r);
		chk(r, 16'h0003);
		rd(ADDR_FLAGS, d);
		chk(d, 8'h01);
		wr(ADDR_FLAGS, 8'h01);
		rd(ADDR_FLAGS, d);
		chk(d, 8'h00);
		wr(ADDR_CONTROL_A, CTRL_RESET);
		for (i = 0; i < 4; i++) begin
			v = rnd();
			wr16(ADDR_COUNT_LOW, v);
			wr(ADDR_CONTROL_B, ctl(i[1], ~i[0]));
			repeat (6) @(negedge core_clk);
			i_src.set_pin(~i[0]);
			wait_irq(1'b0, n);
			lat0 = (i == 0) ? n : lat0;
			if (i == 2) chk(16'(n - lat0), 16'h0004);
			rd(ADDR_FLAGS, d);
			chk(d[CAPTURE_BIT], 1'b1);
			rd16(ADDR_CAPTURE_LOW, r);
			chk(r, v);
			if (i[0]) ack(1'b0);
			else wr(ADDR_FLAGS, 8'h20);
			@(negedge core_clk);
			chk(capture_irq, 1'b0);
		end
		wr(ADDR_CONTROL_B, ctl(1'b1, 1'b1));
		i_src.pulse_pin(3);
		repeat (12) @(negedge core_clk);
		chk(capture_irq, 1'b0);
		i_src.pulse_pin(5);
		wait_irq(1'b0, n);
		v = rnd();
		wr16(ADDR_COUNT_LOW, v);
		i_src.pulse_pin(5);
		repeat (12) @(negedge core_clk);
		rd16(ADDR_CAPTURE_LOW, r);
		chk(r, v);
		wr(ADDR_CONTROL_B, ctl(1'b0, 1'b1));
		wr(ADDR_COMP_CTRL, 8'(1) << COMP_SELECT_BIT);
		wr(ADDR_FLAGS, 8'h20);
		i_src.pulse_pin(3);
		repeat (12) @(negedge core_clk);
		chk(capture_irq, 1'b0);
		i_src.set_comp(1'b1);
		wait_irq(1'b0, n);
		wr(ADDR_COMP_CTRL, 8'h00);
		wr16(ADDR_CAPTURE_LOW, ~v);
		rd16(ADDR_CAPTURE_LOW, r);
		chk(r, v);
		wr(ADDR_CONTROL_B, ctl(1'b0, 1'b1) | 8'h18);
		wr(ADDR_FLAGS, 8'h20);
		v = rnd();
		wr(ADDR_COUNT_HIGH, v[15:8]);
		wr(ADDR_COUNT_LOW, v[7:0]);
		wr(ADDR_CAPTURE_LOW, v[7:0]);
		i_src.pulse_pin(3);
		repeat (12) @(negedge core_clk);
		chk(capture_irq, 1'b0);
		rd16(ADDR_CAPTURE_LOW, r);
		chk(r, v);
		rd16(ADDR_COUNT_LOW, r);
		chk(r, v);
		wr(ADDR_IRQ_MASK, 8'h00);
		wrap_up();
	end
endmodule
